// File: dec_top.sv
`timescale 1ns/1ps
`include "dec_regs.svh"
// Overview of operation
// R1 - Control A bit 0 turns external debug mode on or off.
// R2 - Control A bit 1 turns internal debug mode on or off.
// R3 - Writing reset field 2:3 requests core, chip or system reset; 00 nothing.
// R4 - Bits 4-7 enable completion, branch, exception and trap events.
// R5 - Bits 8, 9, 12, 13 enable the four instruction address match events.
// R6 - Bit 10 pairs instruction matches 1 and 2 into one range.
// R7 - Bit 11 selects inside or outside match for range 1-2.
// R8 - Bit 14 pairs matches 3 and 4; bit 15 picks inside or outside.
// R9 - Bits 16, 17 flip the range's inside/outside choice on each debug event.
// R10 - Bit 31 freezes timers on a debug event, else timers run.
// R11 - Control B bits 0-3 enable read and write events per data match.
// R12 - Size fields mask 0, 1, 2 or 5 low data address bits.
// R13 - Control B bit 8 pairs both data address registers into one range.
// R14 - Bit 9 selects inside or outside match for the data range.
// R15 - Value mode 01 needs every selected lane equal to value register A.
// R16 - Value mode 10 needs any one selected lane equal.
// R17 - Value mode 11 matches on upper or lower halfword; lanes 0011/1100/1111.
// R18 - Value compare B uses mode bits 14:15 against value register B.
// R19 - Lane fields 16:19 and 20:23 pick bytes for value compares A and B.
// R20 - Data address registers hold full 32-bit byte addresses.
// R21 - Each event kind sets its status bit when it occurs.
// R22 - Event with debug exceptions off sets the imprecise flag instead; the code does so only while external debug mode is off.
// R23 - Any reset loads last reset kind into status bits 22:23.
module dec_top
  import dec_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic [9:0] i_spr_addr,
  input  wire logic       i_spr_wr,
  input  wire logic       i_spr_rd,
  input  wire dec_word_t  i_spr_wdata,
  input  wire logic       i_instr_valid,
  input  wire dec_word_t  i_instr_addr,
  input  wire logic       i_branch_taken,
  input  wire logic       i_exception,
  input  wire logic       i_trap,
  input  wire logic       i_uncond_event,
  input  wire logic       i_data_valid,
  input  wire logic       i_data_write,
  input  wire dec_word_t  i_data_addr,
  input  wire dec_word_t  i_data_value,
  input  wire logic       i_debug_exc_en,
  input  wire logic [1:0] i_last_reset_kind,
  output dec_word_t       o_spr_rdata,
  output logic            o_ext_debug_en,
  output logic            o_int_debug_en,
  output logic [1:0]      o_reset_req,
  output logic            o_debug_event,
  output logic            o_freeze_timers
);
  logic       rst_meta_r;
  logic       rst_sync_r;
  dec_word_t  ctl_a_r, ctl_a_nxt;
  dec_word_t  ctl_b_r, ctl_b_nxt;
  dec_word_t  stat_r, stat_nxt;
  dec_word_t  iadr_r [4];
  dec_word_t  iadr_nxt [4];
  dec_word_t  dadr_a_r, dadr_a_nxt;
  dec_word_t  dadr_b_r, dadr_b_nxt;
  dec_word_t  dval_a_r, dval_a_nxt;
  dec_word_t  dval_b_r, dval_b_nxt;
  dec_word_t  rdata_r, rdata_nxt;
  logic [1:0] rst_req_r, rst_req_nxt;
  logic       evt_r, evt_nxt;
  logic       frz_r, frz_nxt;
  logic       cap_done_r;
  logic [3:0] ia_single;
  logic       ra_match, rb_match, dr_match;
  logic       va_match, vb_match;
  logic       da_hit, db_hit;
  dec_word_t  ev;
  logic       any_ev;
  logic       dbg_on;
  logic       wr_a;

  // Reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  function automatic logic spr_hit(input logic [9:0] num);
    return i_spr_wr && (i_spr_addr == num);
  endfunction

  function automatic logic iadr_hit(input dec_word_t ref_addr);
    return (ref_addr[31:2] == i_instr_addr[31:2]);
  endfunction

  dec_range_cmp u_range_a (
    .i_lo        (iadr_r[0]),
    .i_hi        (iadr_r[1]),
    .i_addr      ({i_instr_addr[31:2], 2'b00}),
    .i_exclusive (ctl_a_r[`DEC_CA_RA_X]),
    .o_match     (ra_match)
  );

  dec_range_cmp u_range_b (
    .i_lo        (iadr_r[2]),
    .i_hi        (iadr_r[3]),
    .i_addr      ({i_instr_addr[31:2], 2'b00}),
    .i_exclusive (ctl_a_r[`DEC_CA_RB_X]),
    .o_match     (rb_match)
  );

  dec_range_cmp u_range_d (
    .i_lo        (dadr_a_r),
    .i_hi        (dadr_b_r),
    .i_addr      (i_data_addr),
    .i_exclusive (ctl_b_r[`DEC_CB_DR_X]),
    .o_match     (dr_match)
  ); // R13 R14

  dec_value_cmp u_value_a (
    .i_mode  (ctl_b_r[`DEC_CB_VA_M_HI:`DEC_CB_VA_M_LO]),
    .i_lanes (ctl_b_r[`DEC_CB_VA_BE_HI:`DEC_CB_VA_BE_LO]),
    .i_ref   (dval_a_r),
    .i_data  (i_data_value),
    .o_match (va_match)
  ); // R15 R16 R17 R19

  dec_value_cmp u_value_b (
    .i_mode  (ctl_b_r[`DEC_CB_VB_M_HI:`DEC_CB_VB_M_LO]),
    .i_lanes (ctl_b_r[`DEC_CB_VB_BE_HI:`DEC_CB_VB_BE_LO]),
    .i_ref   (dval_b_r),
    .i_data  (i_data_value),
    .o_match (vb_match)
  ); // R18 R19

  // Event detection
  always_comb begin
    dbg_on = ctl_a_r[`DEC_CA_EXT] | ctl_a_r[`DEC_CA_INT];
    for (int i = 0; i < 4; i++) begin
      ia_single[i] = iadr_hit(iadr_r[i]);
    end
    // Size masking only applies to single-address compares
    da_hit = ctl_b_r[`DEC_CB_DR_EN] ? dr_match : ((i_data_addr & dec_size_mask(ctl_b_r[
      `DEC_CB_A_SZ_HI:`DEC_CB_A_SZ_LO])) == (dadr_a_r & dec_size_mask(ctl_b_r[
      `DEC_CB_A_SZ_HI:`DEC_CB_A_SZ_LO]))); // R12 R20
    db_hit = ctl_b_r[`DEC_CB_DR_EN] ? dr_match : ((i_data_addr & dec_size_mask(ctl_b_r[
      `DEC_CB_B_SZ_HI:`DEC_CB_B_SZ_LO])) == (dadr_b_r & dec_size_mask(ctl_b_r[
      `DEC_CB_B_SZ_HI:`DEC_CB_B_SZ_LO]))); // R12 R20
    da_hit = da_hit & va_match & i_data_valid;
    db_hit = db_hit & vb_match & i_data_valid;
    ev = 32'h00000000;
    ev[`DEC_ST_IC]     = i_instr_valid & ctl_a_r[`DEC_CA_IC]; // R4
    ev[`DEC_ST_BT]     = i_branch_taken & ctl_a_r[`DEC_CA_BT]; // R4
    ev[`DEC_ST_EXC]    = i_exception & ctl_a_r[`DEC_CA_EXC]; // R4
    ev[`DEC_ST_TRAP]   = i_trap & ctl_a_r[`DEC_CA_TRAP]; // R4
    ev[`DEC_ST_UNCOND] = i_uncond_event;
    ev[`DEC_ST_IA1]    = i_instr_valid & ctl_a_r[`DEC_CA_IA1] &
                         (ctl_a_r[`DEC_CA_RA_EN] ? ra_match : ia_single[0]); // R5 R6 R7
    ev[`DEC_ST_IA2]    = i_instr_valid & ctl_a_r[`DEC_CA_IA2] &
                         (ctl_a_r[`DEC_CA_RA_EN] ? ra_match : ia_single[1]); // R5 R6 R7
    ev[`DEC_ST_IA3]    = i_instr_valid & ctl_a_r[`DEC_CA_IA3] &
                         (ctl_a_r[`DEC_CA_RB_EN] ? rb_match : ia_single[2]); // R5 R8
    ev[`DEC_ST_IA4]    = i_instr_valid & ctl_a_r[`DEC_CA_IA4] &
                         (ctl_a_r[`DEC_CA_RB_EN] ? rb_match : ia_single[3]); // R5 R8
    ev[`DEC_ST_DR1]    = da_hit & ~i_data_write & ctl_b_r[`DEC_CB_A_RD]; // R11
    ev[`DEC_ST_DW1]    = da_hit & i_data_write & ctl_b_r[`DEC_CB_A_WR]; // R11
    ev[`DEC_ST_DR2]    = db_hit & ~i_data_write & ctl_b_r[`DEC_CB_B_RD]; // R11
    ev[`DEC_ST_DW2]    = db_hit & i_data_write & ctl_b_r[`DEC_CB_B_WR]; // R11
    ev = dbg_on ? ev : 32'h00000000;
    any_ev = |ev;
  end

  // Register next values
  always_comb begin
    wr_a = spr_hit(`DEC_SPR_CTL_A);
    ctl_a_nxt = ctl_a_r;
    ctl_b_nxt = ctl_b_r;
    stat_nxt = stat_r;
    dadr_a_nxt = spr_hit(`DEC_SPR_DADDR_A) ? i_spr_wdata : dadr_a_r; // R20
    dadr_b_nxt = spr_hit(`DEC_SPR_DADDR_B) ? i_spr_wdata : dadr_b_r; // R20
    dval_a_nxt = spr_hit(`DEC_SPR_DVAL_A) ? i_spr_wdata : dval_a_r;
    dval_b_nxt = spr_hit(`DEC_SPR_DVAL_B) ? i_spr_wdata : dval_b_r;
    iadr_nxt[0] = spr_hit(`DEC_SPR_IADDR_1) ? (i_spr_wdata & `DEC_IADDR_WMASK) : iadr_r[0];
    iadr_nxt[1] = spr_hit(`DEC_SPR_IADDR_2) ? (i_spr_wdata & `DEC_IADDR_WMASK) : iadr_r[1];
    iadr_nxt[2] = spr_hit(`DEC_SPR_IADDR_3) ? (i_spr_wdata & `DEC_IADDR_WMASK) : iadr_r[2];
    iadr_nxt[3] = spr_hit(`DEC_SPR_IADDR_4) ? (i_spr_wdata & `DEC_IADDR_WMASK) : iadr_r[3];
    rst_req_nxt = 2'b00;
    if (wr_a) begin
      ctl_a_nxt = i_spr_wdata & `DEC_CA_WMASK; // R1 R2
      rst_req_nxt = i_spr_wdata[`DEC_CA_RST_HI:`DEC_CA_RST_LO]; // R3
    end
    // Toggle acts on the freshly written value too
    if (any_ev && ctl_a_nxt[`DEC_CA_RA_T]) begin
      ctl_a_nxt[`DEC_CA_RA_X] = ~ctl_a_nxt[`DEC_CA_RA_X]; // R9
    end
    if (any_ev && ctl_a_nxt[`DEC_CA_RB_T]) begin
      ctl_a_nxt[`DEC_CA_RB_X] = ~ctl_a_nxt[`DEC_CA_RB_X]; // R9
    end
    if (spr_hit(`DEC_SPR_CTL_B)) begin
      ctl_b_nxt = i_spr_wdata & `DEC_CB_WMASK;
    end
    if (spr_hit(`DEC_SPR_STATUS)) begin
      stat_nxt = stat_r & ~i_spr_wdata;
    end
    // Set wins over a clear in the same cycle
    stat_nxt = stat_nxt | ev; // R21
    if (any_ev && !ctl_a_r[`DEC_CA_EXT] && !i_debug_exc_en) begin
      stat_nxt[`DEC_ST_IMPRECISE] = 1'b1; // R22
    end
    if (!cap_done_r) begin
      stat_nxt[`DEC_ST_MRR_HI:`DEC_ST_MRR_LO] = i_last_reset_kind; // R23
    end
    evt_nxt = any_ev & (ctl_a_r[`DEC_CA_EXT] | i_debug_exc_en); // R22
    // Held until software clears the status events
    frz_nxt = ctl_a_nxt[`DEC_CA_FT] & (|(stat_nxt & `DEC_ST_EVMASK)); // R10
    rdata_nxt = rdata_r;
    if (i_spr_rd) begin
      unique case (i_spr_addr)
        `DEC_SPR_CTL_A:   rdata_nxt = ctl_a_r;
        `DEC_SPR_CTL_B:   rdata_nxt = ctl_b_r;
        `DEC_SPR_STATUS:  rdata_nxt = stat_r;
        `DEC_SPR_DADDR_A: rdata_nxt = dadr_a_r;
        `DEC_SPR_DADDR_B: rdata_nxt = dadr_b_r;
        `DEC_SPR_DVAL_A:  rdata_nxt = dval_a_r;
        `DEC_SPR_DVAL_B:  rdata_nxt = dval_b_r;
        `DEC_SPR_IADDR_1: rdata_nxt = iadr_r[0];
        `DEC_SPR_IADDR_2: rdata_nxt = iadr_r[1];
        `DEC_SPR_IADDR_3: rdata_nxt = iadr_r[2];
        `DEC_SPR_IADDR_4: rdata_nxt = iadr_r[3];
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctl_a_r    <= `DEC_REG_RESET;
      ctl_b_r    <= `DEC_REG_RESET;
      stat_r     <= `DEC_REG_RESET;
      dadr_a_r   <= `DEC_REG_RESET;
      dadr_b_r   <= `DEC_REG_RESET;
      dval_a_r   <= `DEC_REG_RESET;
      dval_b_r   <= `DEC_REG_RESET;
      for (int i = 0; i < 4; i++) begin
        iadr_r[i] <= `DEC_REG_RESET;
      end
      rdata_r    <= `DEC_REG_RESET;
      rst_req_r  <= 2'b00;
      evt_r      <= 1'b0;
      frz_r      <= 1'b0;
      cap_done_r <= 1'b0;
    end else begin
      ctl_a_r    <= ctl_a_nxt;
      ctl_b_r    <= ctl_b_nxt;
      stat_r     <= stat_nxt;
      dadr_a_r   <= dadr_a_nxt;
      dadr_b_r   <= dadr_b_nxt;
      dval_a_r   <= dval_a_nxt;
      dval_b_r   <= dval_b_nxt;
      for (int i = 0; i < 4; i++) begin
        iadr_r[i] <= iadr_nxt[i];
      end
      rdata_r    <= rdata_nxt;
      rst_req_r  <= rst_req_nxt;
      evt_r      <= evt_nxt;
      frz_r      <= frz_nxt;
      cap_done_r <= 1'b1;
    end
  end

  assign o_spr_rdata     = rdata_r;
  assign o_ext_debug_en  = ctl_a_r[`DEC_CA_EXT];
  assign o_int_debug_en  = ctl_a_r[`DEC_CA_INT];
  assign o_reset_req     = rst_req_r;
  assign o_debug_event   = evt_r;
  assign o_freeze_timers = frz_r;

  property p_ext_mode;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    spr_hit(`DEC_SPR_CTL_A) |=> o_ext_debug_en == $past(i_spr_wdata[`DEC_CA_EXT]);
  endproperty
  a_ext_mode: assert property (p_ext_mode) else $error("external mode bit not taken"); // R1

  property p_int_mode;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    spr_hit(`DEC_SPR_CTL_A) |=> o_int_debug_en == $past(i_spr_wdata[`DEC_CA_INT]);
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("internal mode bit not taken"); // R2

  property p_reset_req;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    !spr_hit(`DEC_SPR_CTL_A) |=> o_reset_req == 2'b00;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset request without write"); // R3

  property p_branch_cause;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    $rose(stat_r[`DEC_ST_BT]) |-> $past(i_branch_taken) && $past(ctl_a_r[`DEC_CA_BT]);
  endproperty
  a_branch_cause: assert property (p_branch_cause) else $error("branch status without cause"); // R4

  property p_trap_set;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    i_trap && ctl_a_r[`DEC_CA_TRAP] && dbg_on |=> stat_r[`DEC_ST_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set) else $error("trap event not recorded"); // R21

  property p_toggle;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    any_ev && !wr_a && ctl_a_r[`DEC_CA_RA_T]
      |=> ctl_a_r[`DEC_CA_RA_X] != $past(ctl_a_r[`DEC_CA_RA_X]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("range a exclusive did not flip"); // R9

  property p_freeze;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    o_freeze_timers |-> ctl_a_r[`DEC_CA_FT] && (|(stat_r & `DEC_ST_EVMASK));
  endproperty
  a_freeze: assert property (p_freeze) else $error("timers frozen without cause"); // R10

  property p_imprecise;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    any_ev && !ctl_a_r[`DEC_CA_EXT] && !i_debug_exc_en
      |=> stat_r[`DEC_ST_IMPRECISE] && !o_debug_event;
  endproperty
  a_imprecise: assert property (p_imprecise) else $error("imprecise flag missed"); // R22

  property p_data_read;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    $rose(stat_r[`DEC_ST_DR1]) |-> $past(ctl_b_r[`DEC_CB_A_RD]) && $past(i_data_valid)
      && !$past(i_data_write);
  endproperty
  a_data_read: assert property (p_data_read) else $error("read match without cause"); // R11

  property p_last_reset;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    !cap_done_r |=> stat_r[`DEC_ST_MRR_HI:`DEC_ST_MRR_LO] == $past(i_last_reset_kind);
  endproperty
  a_last_reset: assert property (p_last_reset) else $error("last reset kind not caught"); // R23
endmodule // dec_top

// File: dec_regs.svh
`ifndef DEC_REGS_SVH
`define DEC_REGS_SVH

// Register numbers on the special-purpose register port
`define DEC_SPR_CTL_B      10'h3bd
`define DEC_SPR_STATUS     10'h3f0
`define DEC_SPR_CTL_A      10'h3f2
`define DEC_SPR_DADDR_A    10'h3f6
`define DEC_SPR_DADDR_B    10'h3f7
`define DEC_SPR_DVAL_A     10'h3b6
`define DEC_SPR_DVAL_B     10'h3b7
`define DEC_SPR_IADDR_1    10'h3f4
`define DEC_SPR_IADDR_2    10'h3f5
`define DEC_SPR_IADDR_3    10'h3b4
`define DEC_SPR_IADDR_4    10'h3b5

// Field positions, vector index = 31 - big-endian bit number
`define DEC_CA_EXT         31
`define DEC_CA_INT         30
`define DEC_CA_RST_HI      29
`define DEC_CA_RST_LO      28
`define DEC_CA_IC          27
`define DEC_CA_BT          26
`define DEC_CA_EXC         25
`define DEC_CA_TRAP        24
`define DEC_CA_IA1         23
`define DEC_CA_IA2         22
`define DEC_CA_RA_EN       21
`define DEC_CA_RA_X        20
`define DEC_CA_IA3         19
`define DEC_CA_IA4         18
`define DEC_CA_RB_EN       17
`define DEC_CA_RB_X        16
`define DEC_CA_RA_T        15
`define DEC_CA_RB_T        14
`define DEC_CA_FT          0

`define DEC_CB_A_RD        31
`define DEC_CB_B_RD        30
`define DEC_CB_A_WR        29
`define DEC_CB_B_WR        28
`define DEC_CB_A_SZ_HI     27
`define DEC_CB_A_SZ_LO     26
`define DEC_CB_B_SZ_HI     25
`define DEC_CB_B_SZ_LO     24
`define DEC_CB_DR_EN       23
`define DEC_CB_DR_X        22
`define DEC_CB_VA_M_HI     19
`define DEC_CB_VA_M_LO     18
`define DEC_CB_VB_M_HI     17
`define DEC_CB_VB_M_LO     16
`define DEC_CB_VA_BE_HI    15
`define DEC_CB_VA_BE_LO    12
`define DEC_CB_VB_BE_HI    11
`define DEC_CB_VB_BE_LO    8

`define DEC_ST_IC          31
`define DEC_ST_BT          30
`define DEC_ST_EXC         29
`define DEC_ST_TRAP        28
`define DEC_ST_UNCOND      27
`define DEC_ST_IA1         26
`define DEC_ST_IA2         25
`define DEC_ST_DR1         24
`define DEC_ST_DW1         23
`define DEC_ST_DR2         22
`define DEC_ST_DW2         21
`define DEC_ST_IMPRECISE   20
`define DEC_ST_IA3         19
`define DEC_ST_IA4         18
`define DEC_ST_MRR_HI      9
`define DEC_ST_MRR_LO      8

// Writable bits and reset values
`define DEC_CA_WMASK       32'hcfffc001
`define DEC_CB_WMASK       32'hffcfff00
`define DEC_ST_EVMASK      32'hfffc0000
`define DEC_IADDR_WMASK    32'hfffffffc
`define DEC_REG_RESET      32'h00000000
`endif

// File: dec_pkg.sv
package dec_pkg;
  typedef logic [31:0] dec_word_t;
  typedef enum logic [1:0] {DEC_VM_UNDEF, DEC_VM_AND, DEC_VM_OR, DEC_VM_ANDOR} dec_vmode_t;
  typedef enum logic [1:0] {DEC_SZ_BYTE, DEC_SZ_HALF, DEC_SZ_WORD, DEC_SZ_LINE} dec_size_t;

  // Address bits examined for a given compare size
  function automatic dec_word_t dec_size_mask(input logic [1:0] size);
    dec_word_t m;
    m = 32'hffffffff;
    unique case (dec_size_t'(size))
      DEC_SZ_BYTE: m = 32'hffffffff;
      DEC_SZ_HALF: m = 32'hfffffffe;
      DEC_SZ_WORD: m = 32'hfffffffc;
      DEC_SZ_LINE: m = 32'hffffffe0;
    endcase
    return m;
  endfunction
endpackage

// File: dec_range_cmp.sv
`timescale 1ns/1ps
module dec_range_cmp
  import dec_pkg::*;
(
  input  wire dec_word_t i_lo,
  input  wire dec_word_t i_hi,
  input  wire dec_word_t i_addr,
  input  wire logic      i_exclusive,
  output logic           o_match
);
  // Lower bound inclusive, upper bound exclusive
  assign o_match = ((i_addr >= i_lo) && (i_addr < i_hi)) ^ i_exclusive;
endmodule // dec_range_cmp

// File: dec_value_cmp.sv
`timescale 1ns/1ps
module dec_value_cmp
  import dec_pkg::*;
(
  input  wire logic [1:0] i_mode,
  input  wire logic [3:0] i_lanes,
  input  wire dec_word_t  i_ref,
  input  wire dec_word_t  i_data,
  output logic            o_match
);
  logic [3:0] eq;
  logic       hi_ok;
  logic       lo_ok;

  // Lane 3 is the most significant byte
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eq[i] = (i_ref[i*8 +: 8] == i_data[i*8 +: 8]);
    end
    hi_ok = (i_lanes[3] | i_lanes[2]) & (~i_lanes[3] | eq[3]) & (~i_lanes[2] | eq[2]);
    lo_ok = (i_lanes[1] | i_lanes[0]) & (~i_lanes[1] | eq[1]) & (~i_lanes[0] | eq[0]);
    o_match = 1'b1;
    unique case (dec_vmode_t'(i_mode))
      DEC_VM_UNDEF: o_match = 1'b1;
      DEC_VM_AND:   o_match = &(eq | ~i_lanes);
      DEC_VM_OR:    o_match = |(eq & i_lanes);
      DEC_VM_ANDOR: o_match = hi_ok | lo_ok;
    endcase
  end
endmodule // dec_value_cmp

// File: dec_core_model.sv
`timescale 1ns/1ps
module dec_core_model
  import dec_pkg::*;
(
  input  wire logic i_sys_clk,
  output logic      o_instr_valid,
  output dec_word_t o_instr_addr,
  output logic      o_branch_taken,
  output logic      o_exception,
  output logic      o_trap,
  output logic      o_data_valid,
  output logic      o_data_write,
  output dec_word_t o_data_addr,
  output dec_word_t o_data_value
);
  initial begin
    {o_instr_valid, o_branch_taken, o_exception, o_trap} = 4'h0;
    {o_data_valid, o_data_write} = 2'h0;
    o_instr_addr = 32'h0;
    o_data_addr = 32'h0;
    o_data_value = 32'h0;
  end

  // One-cycle pulse; caller enters just after a rising edge
  task automatic retire(input dec_word_t a, input logic [3:0] ev);
    o_instr_addr = a;
    {o_instr_valid, o_branch_taken, o_exception, o_trap} = ev;
    @(posedge i_sys_clk);
    #1;
    {o_instr_valid, o_branch_taken, o_exception, o_trap} = 4'h0;
    // Stale address never left standing, so a late sample cannot pass
    o_instr_addr = ~a;
  endtask

  task automatic access(input logic w, input dec_word_t a, input dec_word_t v);
    o_data_write = w;
    o_data_addr = a;
    o_data_value = v;
    o_data_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_data_valid = 1'b0;
    o_data_write = ~w;
    o_data_addr = ~a;
    o_data_value = ~v;
  endtask
endmodule  // dec_core_model

// File: dec_top_tb.sv
`timescale 1ns/1ps
`include "dec_regs.svh"
module dec_top_tb
  import dec_pkg::*;
;
  localparam logic [9:0] CA = `DEC_SPR_CTL_A;
  localparam logic [9:0] CB = `DEC_SPR_CTL_B;
  localparam logic [9:0] ST = `DEC_SPR_STATUS;
  localparam dec_word_t  ALL = 32'hffffffff;
  localparam dec_word_t  DA = 32'h80000100;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [9:0] spr_addr = 10'h000;
  logic       spr_wr = 1'b0;
  logic       spr_rd = 1'b0;
  dec_word_t  spr_wdata = 32'h0;
  logic       exc_en = 1'b1;
  logic       uev = 1'b0;
  logic [1:0] last_kind = 2'h2;
  logic       iv, bt, exc, trap, dv, dw, ext_en, int_en, dbg_ev, freeze;
  dec_word_t  ia, dadr, dval, rdata;
  logic [1:0] reset_req;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         ign[4] = '{0, 1, 2, 5};
  dec_word_t  vd[8] = '{32'h11223344, 32'h11223345, 32'h00000044, 32'h44332211,
                        32'h1122ffff, 32'h11ffff44, 32'hffffff44, 32'h11223300};

  always #12.5 sys_clk = ~sys_clk;

  dec_top dec_top_i (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_spr_addr(spr_addr),
    .i_spr_wr(spr_wr), .i_spr_rd(spr_rd), .i_spr_wdata(spr_wdata),
    .i_instr_valid(iv), .i_instr_addr(ia), .i_branch_taken(bt), .i_exception(exc),
    .i_trap(trap), .i_uncond_event(uev), .i_data_valid(dv), .i_data_write(dw),
    .i_data_addr(dadr), .i_data_value(dval), .i_debug_exc_en(exc_en),
    .i_last_reset_kind(last_kind), .o_spr_rdata(rdata), .o_ext_debug_en(ext_en),
    .o_int_debug_en(int_en), .o_reset_req(reset_req), .o_debug_event(dbg_ev),
    .o_freeze_timers(freeze));

  dec_core_model dec_core_model_i (
    .i_sys_clk(sys_clk), .o_instr_valid(iv), .o_instr_addr(ia), .o_branch_taken(bt),
    .o_exception(exc), .o_trap(trap), .o_data_valid(dv), .o_data_write(dw),
    .o_data_addr(dadr), .o_data_value(dval));

  function automatic dec_word_t b(input int i);
    return 32'h1 << i;
  endfunction

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input dec_word_t v);
    // Idle edge first, so back-to-back calls never re-drive the strobe at once
    tick();
    spr_addr = a;
    spr_wdata = v;
    spr_wr = 1'b1;
    tick();
    spr_wr = 1'b0;
  endtask

  task automatic chk(input string n, input dec_word_t e, input dec_word_t g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_reg(input string n, input logic [9:0] a, input dec_word_t m,
                         input dec_word_t e);
    tick();
    spr_addr = a;
    spr_rd = 1'b1;
    tick();
    spr_rd = 1'b0;
    chk(n, e, rdata & m);
  endtask

  // Status is sticky, so every look is followed by a clear
  task automatic st_chk(input string n, input dec_word_t e);
    chk_reg(n, ST, `DEC_ST_EVMASK, e);
    wr(ST, ALL);
  endtask

  task automatic do_reset(input logic [1:0] k);
    last_kind = k;
    reset_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) tick();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is a few hundred cycles; generous ceiling
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    do_reset(2'h2);
    chk_reg("status rst", ST, `DEC_ST_EVMASK | 32'h300, 32'h200);
    chk_reg("ctl_a rst", CA, ALL, 32'h0);
    wr(CA, `DEC_CA_WMASK);
    chk_reg("ctl_a rw", CA, ALL, `DEC_CA_WMASK);
    chk("ext_en", 1, ext_en);
    chk("int_en", 1, int_en);
    wr(CB, ALL);
    chk_reg("ctl_b rw", CB, ALL, `DEC_CB_WMASK);
    wr(CA, 32'h0);
    chk("ext_en off", 0, ext_en);
    chk("int_en off", 0, int_en);
    for (int k = 0; k < 4; k++) begin
      wr(CA, k << `DEC_CA_RST_LO);
      chk("reset_req", k, reset_req);
      tick();
      chk("reset_req end", 0, reset_req);
    end
    wr(CA, 32'hf << `DEC_CA_TRAP);
    dec_core_model_i.retire(32'h40, 4'hf);
    st_chk("modes off", 0);
    wr(CA, b(`DEC_CA_INT) | 32'hf << `DEC_CA_TRAP);
    for (int i = 0; i < 4; i++) begin
      dec_core_model_i.retire(32'h40, 4'h8 >> i);
      chk("debug_event", 1, dbg_ev);
      st_chk("event", b(`DEC_ST_IC - i));
    end
    wr(CA, b(`DEC_CA_INT));
    dec_core_model_i.retire(32'h40, 4'hf);
    st_chk("event off", 0);
    uev = 1'b1;
    tick();
    uev = 1'b0;
    st_chk("uncond", b(`DEC_ST_UNCOND));
    for (int r = 0; r < 2; r++) begin
      wr(10'(`DEC_SPR_IADDR_1 - 'h40 * r), 32'h1000);
      wr(10'(`DEC_SPR_IADDR_2 - 'h40 * r), 32'h2000);
      wr(CA, b(`DEC_CA_INT) | b(`DEC_CA_IA1 - 4 * r));
      dec_core_model_i.retire(32'h1000, 4'h8);
      st_chk("ia single", b(`DEC_ST_IA1 - 7 * r));
      dec_core_model_i.retire(32'h1004, 4'h8);
      st_chk("ia single miss", 0);
      wr(CA, b(`DEC_CA_INT) | b(`DEC_CA_IA1 - 4 * r) | b(`DEC_CA_RA_EN - 4 * r)
             | b(`DEC_CA_RA_T - r));
      dec_core_model_i.retire(32'h1ffc, 4'h8);
      st_chk("range in", b(`DEC_ST_IA1 - 7 * r));
      chk_reg("toggled", CA, b(`DEC_CA_RA_X - 4 * r), b(`DEC_CA_RA_X - 4 * r));
      dec_core_model_i.retire(32'h1800, 4'h8);
      st_chk("excl inside", 0);
      dec_core_model_i.retire(32'h2000, 4'h8);
      st_chk("excl outside", b(`DEC_ST_IA1 - 7 * r));
      dec_core_model_i.retire(32'h0ffc, 4'h8);
      st_chk("incl outside", 0);
    end
    wr(`DEC_SPR_DADDR_A, DA);
    for (int s = 0; s < 4; s++) begin
      wr(CB, b(`DEC_CB_A_RD) | s << `DEC_CB_A_SZ_LO);
      dec_core_model_i.access(0, DA + (32'h1 << ign[s]) - 1, 0);
      st_chk("size hit", b(`DEC_ST_DR1));
      dec_core_model_i.access(0, DA + (32'h1 << ign[s]), 0);
      st_chk("size miss", 0);
    end
    dec_core_model_i.access(1, DA, 0);
    st_chk("write off", 0);
    wr(CB, b(`DEC_CB_A_WR));
    dec_core_model_i.access(1, DA, 0);
    st_chk("write hit", b(`DEC_ST_DW1));
    wr(`DEC_SPR_DVAL_A, 32'h11223344);
    for (int i = 0; i < 8; i++) begin
      wr(CB, b(`DEC_CB_A_RD) | (i < 6 ? i / 2 + 1 : 1) << `DEC_CB_VA_M_LO
             | (i < 6 ? 32'hf : 32'h1) << `DEC_CB_VA_BE_LO);
      dec_core_model_i.access(0, DA, vd[i]);
      st_chk("value a", i % 2 ? 0 : b(`DEC_ST_DR1));
    end
    wr(`DEC_SPR_DADDR_B, DA + 32'h100);
    wr(CB, b(`DEC_CB_A_RD) | b(`DEC_CB_DR_EN));
    dec_core_model_i.access(0, DA + 32'h80, 0);
    st_chk("drange in", b(`DEC_ST_DR1));
    wr(CB, b(`DEC_CB_A_RD) | b(`DEC_CB_DR_EN) | b(`DEC_CB_DR_X));
    dec_core_model_i.access(0, DA + 32'h80, 0);
    st_chk("drange excl in", 0);
    dec_core_model_i.access(0, DA + 32'h100, 0);
    st_chk("drange excl out", b(`DEC_ST_DR1));
    wr(`DEC_SPR_DVAL_B, 32'hcafe0001);
    wr(CB, b(`DEC_CB_B_RD) | 32'h1 << `DEC_CB_VB_M_LO | 32'hf << `DEC_CB_VB_BE_LO);
    dec_core_model_i.access(0, DA + 32'h100, 32'hcafe0001);
    st_chk("value b", b(`DEC_ST_DR2));
    dec_core_model_i.access(0, DA + 32'h100, 32'hcafe0002);
    st_chk("value b miss", 0);
    exc_en = 1'b0;
    wr(CA, b(`DEC_CA_INT) | b(`DEC_CA_TRAP));
    dec_core_model_i.retire(32'h0, 4'h1);
    chk("no exception", 0, dbg_ev);
    st_chk("imprecise", b(`DEC_ST_TRAP) | b(`DEC_ST_IMPRECISE));
    exc_en = 1'b1;
    wr(CA, b(`DEC_CA_INT) | b(`DEC_CA_TRAP) | b(`DEC_CA_FT));
    dec_core_model_i.retire(32'h0, 4'h1);
    tick();
    chk("freeze", 1, freeze);
    st_chk("freeze ev", b(`DEC_ST_TRAP));
    tick();
    chk("freeze clr", 0, freeze);
    wr(CA, b(`DEC_CA_INT) | b(`DEC_CA_TRAP));
    dec_core_model_i.retire(32'h0, 4'h1);
    tick();
    chk("run on", 0, freeze);
    wr(10'h3ff, ALL);
    chk_reg("unmapped", 10'h3ff, ALL, 32'h0);
    do_reset(2'h3);
    chk_reg("status rst 2", ST, 32'h300, 32'h300);
    tally_and_finish();
  end
endmodule  // dec_top_tb
